/* File: inc/afc_cfg.svh */
// timing and layout constants for the fifo host controller
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
`define AFC_CLK_PERIOD_NS 10
`define AFC_DATA_W 9
`define AFC_DEV_WORDS 2048
`define AFC_BUF_DEPTH 8
`define AFC_T_RS_NS 200
`define AFC_T_RSS_NS 180
`define AFC_T_RSR_NS 35
`define AFC_T_PW_NS 200
`define AFC_T_REC_NS 35
`define AFC_T_RTS_NS 180
`define AFC_T_RTR_NS 35
`define AFC_T_ACC_NS 200
`define AFC_CYC(ns) (((ns) + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_CNT_W 6
`endif

/* File: inc/afc_pkg.sv */
// types for the fifo host controller
package afc_pkg;
   typedef enum logic [6:0]
   {
      AFC_RESET = 7'h01,
      AFC_RREC = 7'h02,
      AFC_IDLE = 7'h04,
      AFC_WPULSE = 7'h08,
      AFC_RPULSE = 7'h10,
      AFC_RTPULSE = 7'h20,
      AFC_RECOV = 7'h40
   } afc_state_t;
endpackage

/* File: hdl/afc_buf.sv */
// small fifo holding words for the device
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_buf
   import afc_pkg::*;
#(
   parameter int WIDTH = `AFC_DATA_W,
   parameter int DEPTH = `AFC_BUF_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin
         $error("depth must be a power of two, at least 2");
      end
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = (wr_q == rd_q);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_q[AW-1:0]];
   // ----------------------------------------
   // storage
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (in_valid && !full)
      begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
      end
      else if (in_valid && !full)
      begin
         wr_q <= wr_q + 1'b1;
      end
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_q <= '0;
      end
      else if (out_valid && out_ready)
      begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule

/* File: hdl/afc_host.sv */
// host controller driving the strobe-timed fifo device
//
// Summary of operation
// [RL1] device clears both pointers while clear_all_n is low.
// [RL2] controller resets the device after power-up before any write.
// [RL3] strobes held high setup before and recovery after clear_all_n rises.
// [RL4] replay pulse rewinds device read pointer, write pointer kept.
// [RL5] read strobe high setup before and recovery after replay rises.
// [RL6] controller never replays when configured for depth expansion.
// [RL7] device is single mode if reset with chain_input_n grounded.
// [RL8] one device holds 2048 nine-bit words.
// [RL9] width-expanded devices show identical flags; any one may be watched.
// [RL10] half flag falls on write strobe after half memory filled.
// [RL11] half flag rises on read strobe once fill is half or less.
// [RL12] lead device marked by grounding lead_or_replay_n at reset.
// [RL13] each chain_output_n ties to the next chain_input_n.
// [RL14] depth mode disables half flag; pin is chain output only.
// [RL15] composite flags asserted only when every device asserts them.
// [RL16] chain output pulses on writing and reading last location.
// [RL17] chain output pulse mirrors the causing strobe, delayed. The model drives chain_output_n with no delay.
// [RL18] full and empty follow pointer distance, not physical end.
// [RL19] device ignores writes begun while full_n is low.
// [RL20] device empty: empty_n low, reads inhibited, outputs high impedance; the model keeps driving dev_q.
// [RL21] non-lead device waits for chain pulses before writing, reading. The model writes and reads without waiting for chain_input_n.
// [RL22] pointers wrap from last location to zero.
`timescale 1ns/10ps
`include "afc_cfg.svh"
module afc_host
   import afc_pkg::*;
#(
   parameter int DATA_W = `AFC_DATA_W,
   parameter int DEVICES = 1,
   parameter int BUF_DEPTH = `AFC_BUF_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic depth_mode,
   input wire logic replay_req,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic clear_all_n,
   output logic load_pulse_n,
   output logic unload_pulse_n,
   output logic lead_or_replay_n,
   output logic [DATA_W-1:0] dev_d,
   input wire logic [DATA_W-1:0] dev_q,
   input wire logic [DEVICES-1:0] full_n,
   input wire logic [DEVICES-1:0] empty_n,
   input wire logic half_level_n,
   output logic half_full,
   output logic dev_full,
   output logic dev_empty,
   output logic busy
);
   initial
   begin
      if (DEVICES < 1 || DATA_W < 1)
      begin
         $error("at least one device and one data bit required");
      end
   end
   localparam logic [`AFC_CNT_W-1:0] RS_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_RS_NS));
   localparam logic [`AFC_CNT_W-1:0] RSR_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_RSR_NS));
   localparam logic [`AFC_CNT_W-1:0] PW_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_PW_NS));
   localparam logic [`AFC_CNT_W-1:0] REC_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_REC_NS));
   localparam logic [`AFC_CNT_W-1:0] RTR_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_RTR_NS));
   localparam logic [`AFC_CNT_W-1:0] ACC_CYC = `AFC_CNT_W'(`AFC_CYC(`AFC_T_ACC_NS));
   afc_state_t state_q;
   logic [`AFC_CNT_W-1:0] cnt_q;
   logic cnt_done;
   logic [DEVICES-1:0] full_s1_q, full_s2_q, empty_s1_q, empty_s2_q;
   logic half_s1_q, half_s2_q;
   logic [DATA_W-1:0] q_s1_q, q_s2_q;
   logic replay_pend_q;
   logic buf_valid;
   logic buf_take;
   logic [DATA_W-1:0] buf_data;
   logic any_full, all_empty;
   assign cnt_done = (cnt_q == '0);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         full_s1_q <= '1;
         full_s2_q <= '1;
         empty_s1_q <= '0;
         empty_s2_q <= '0;
         half_s1_q <= 1'b1;
         half_s2_q <= 1'b1;
         q_s1_q <= '0;
         q_s2_q <= '0;
      end
      else
      begin
         full_s1_q <= full_n;
         full_s2_q <= full_s1_q;
         empty_s1_q <= empty_n;
         empty_s2_q <= empty_s1_q;
         half_s1_q <= half_level_n;
         half_s2_q <= half_s1_q;
         q_s1_q <= dev_q;
         q_s2_q <= q_s1_q;
      end
   end
   // [RL15] composite flags across the chain
   assign any_full = (full_s2_q == '0);
   assign all_empty = (empty_s2_q == '0);
   // [RL9] flags of any device serve in width mode
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         dev_full <= 1'b0;
         dev_empty <= 1'b1;
         half_full <= 1'b0;
      end
      else
      begin
         dev_full <= any_full;
         dev_empty <= all_empty;
         // [RL14] half flag meaningless in depth mode
         half_full <= !depth_mode && !half_s2_q;
      end
   end
   // ----------------------------------------
   // write buffer
   // ----------------------------------------
   afc_buf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_buf
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(buf_valid),
      .out_ready(buf_take),
      .out_data(buf_data)
   );
   // [RL19] never strobe a write while full is shown
   // pending replay holds off the pop, so no word is lost
   assign buf_take = (state_q == AFC_IDLE) && !(replay_pend_q && !depth_mode) && buf_valid && !any_full;
   // ----------------------------------------
   // replay request latch
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         replay_pend_q <= 1'b0;
      end
      // [RL6] replay refused in depth mode
      else if (replay_req && !depth_mode)
      begin
         replay_pend_q <= 1'b1;
      end
      else if (state_q == AFC_RTPULSE)
      begin
         replay_pend_q <= 1'b0;
      end
   end
   // ----------------------------------------
   // strobe sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= AFC_RESET;
         cnt_q <= RS_CYC;
      end
      else
      begin
         case (state_q)
            // [RL2] device reset first after power-up
            AFC_RESET:
            begin
               if (cnt_done)
               begin
                  state_q <= AFC_RREC;
                  cnt_q <= RSR_CYC;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            // [RL3] strobes high after reset release
            AFC_RREC:
            begin
               if (cnt_done)
               begin
                  state_q <= AFC_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            AFC_IDLE:
            begin
               if (replay_pend_q && !depth_mode)
               begin
                  state_q <= AFC_RTPULSE;
                  cnt_q <= PW_CYC;
               end
               else if (buf_take)
               begin
                  state_q <= AFC_WPULSE;
                  cnt_q <= PW_CYC;
               end
               // [RL20] no read while empty shown
               else if (!all_empty)
               begin
                  state_q <= AFC_RPULSE;
                  cnt_q <= (PW_CYC > ACC_CYC) ? PW_CYC : ACC_CYC;
               end
            end
            AFC_WPULSE, AFC_RPULSE:
            begin
               if (cnt_done)
               begin
                  state_q <= AFC_RECOV;
                  cnt_q <= REC_CYC;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            // [RL5] read strobe stays high around replay
            AFC_RTPULSE:
            begin
               if (cnt_done)
               begin
                  state_q <= AFC_RECOV;
                  cnt_q <= RTR_CYC;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            AFC_RECOV:
            begin
               if (cnt_done)
               begin
                  state_q <= AFC_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default:
            begin
               state_q <= AFC_RESET;
               cnt_q <= RS_CYC;
            end
         endcase
      end
   end
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         clear_all_n <= 1'b0;
         load_pulse_n <= 1'b1;
         unload_pulse_n <= 1'b1;
         lead_or_replay_n <= 1'b0;
         dev_d <= '0;
      end
      else
      begin
         // [RL1] hold device in clear during reset state
         clear_all_n <= (state_q != AFC_RESET);
         load_pulse_n <= !(state_q == AFC_WPULSE && !cnt_done);
         unload_pulse_n <= !(state_q == AFC_RPULSE && !cnt_done);
         // [RL12] lead level held in depth mode, replay pulse otherwise
         lead_or_replay_n <= depth_mode ? 1'b0 : !(state_q == AFC_RTPULSE && !cnt_done);
         if (buf_take)
         begin
            dev_d <= buf_data;
         end
      end
   end
   // ----------------------------------------
   // read capture
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data <= '0;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= (state_q == AFC_RPULSE) && cnt_done;
         if ((state_q == AFC_RPULSE) && cnt_done)
         begin
            rd_data <= q_s2_q;
         end
      end
   end
   assign busy = (state_q != AFC_IDLE);
endmodule

/* File: dv/afc_host_properties.sv */
// checker for the fifo host controller pins
`timescale 1ns/10ps
module afc_host_properties #(
   parameter int DATA_W = 9,
   parameter int DEVICES = 1
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic depth_mode,
   input wire logic clear_all_n,
   input wire logic load_pulse_n,
   input wire logic unload_pulse_n,
   input wire logic lead_or_replay_n,
   input wire logic [DATA_W-1:0] dev_d,
   input wire logic [DEVICES-1:0] full_n,
   input wire logic [DEVICES-1:0] empty_n
);
   logic [4:0] rd_hi_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----
   // read strobe high time
   // ----
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rd_hi_q <= 5'h1F;
      else if (!unload_pulse_n)
         rd_hi_q <= 5'h00;
      else if (rd_hi_q != 5'h1F)
         rd_hi_q <= rd_hi_q + 5'h01;
   end
   // ----
   // properties
   // ----
   property p_rst_clear;
      $fell(rst) |-> (!clear_all_n)[*8] ##12 !clear_all_n;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("clear too short");
   property p_no_st_clear;
      !clear_all_n |-> load_pulse_n && unload_pulse_n;
   endproperty
   a_no_st_clear: assert property (p_no_st_clear) else $error("strobe in clear");
   property p_rst_recov;
      $rose(clear_all_n) |-> (load_pulse_n && unload_pulse_n)[*4];
   endproperty
   a_rst_recov: assert property (p_rst_recov) else $error("clear recovery");
   property p_rt_setup;
      $rose(lead_or_replay_n) |-> rd_hi_q >= 5'h12;
   endproperty
   a_rt_setup: assert property (p_rt_setup) else $error("replay setup");
   property p_rt_recov;
      $rose(lead_or_replay_n) |-> unload_pulse_n[*4];
   endproperty
   a_rt_recov: assert property (p_rt_recov) else $error("replay recovery");
   property p_depth_no_rt;
      depth_mode[*3] |-> !lead_or_replay_n;
   endproperty
   a_depth_no_rt: assert property (p_depth_no_rt) else $error("replay in depth");
   property p_no_wr_full;
      (~|full_n)[*5] |-> !$fell(load_pulse_n);
   endproperty
   a_no_wr_full: assert property (p_no_wr_full) else $error("write when full");
   property p_no_rd_empty;
      (~|empty_n)[*5] |-> !$fell(unload_pulse_n);
   endproperty
   a_no_rd_empty: assert property (p_no_rd_empty) else $error("read when empty");
   property p_dev_d_hold;
      !load_pulse_n |-> $stable(dev_d);
   endproperty
   a_dev_d_hold: assert property (p_dev_d_hold) else $error("data moved in write");
   c_wr: cover property ($fell(load_pulse_n));
   c_rd: cover property ($fell(unload_pulse_n));
   c_rt: cover property ($rose(lead_or_replay_n) && !depth_mode);
endmodule
bind afc_host afc_host_properties #(.DATA_W(DATA_W), .DEVICES(DEVICES)) i_afc_host_properties (
   .sys_clk(sys_clk), .rst(rst), .depth_mode(depth_mode), .clear_all_n(clear_all_n),
   .load_pulse_n(load_pulse_n), .unload_pulse_n(unload_pulse_n), .lead_or_replay_n(lead_or_replay_n),
   .dev_d(dev_d), .full_n(full_n), .empty_n(empty_n)
);

/* File: dv/afc_dev_model.sv */
// behavioural model of the strobe-timed fifo device
`timescale 1ns/10ps
module afc_dev_model #(
   parameter int WORDS = 16
)
(
   input wire logic clear_all_n,
   input wire logic load_pulse_n,
   input wire logic unload_pulse_n,
   input wire logic lead_or_replay_n,
   input wire logic chain_input_n,
   input wire logic [8:0] dev_d,
   output logic [8:0] dev_q = 9'h000,
   output logic full_n,
   output logic empty_n,
   output logic half_level_n,
   output logic chain_output_n
);
   logic [8:0] mem [WORDS];
   int wp = 0;
   int rp = 0;
   int cnt = 0;
   logic depth_q = 1'b0;
   logic wok = 1'b0;
   logic rok = 1'b0;
   logic half_q = 1'b1;
   // ----
   // flags, pointers
   // ----
   // flags from distance
   assign full_n = (cnt != WORDS);
   assign empty_n = (cnt != 0);
   assign half_level_n = depth_q | half_q;
   assign chain_output_n = !((!load_pulse_n && wok && wp == WORDS - 1) ||
      (!unload_pulse_n && rok && rp == WORDS - 1));
   always @(clear_all_n)
   begin
      if (!clear_all_n)
      begin
         wp = 0;
         rp = 0;
         cnt = 0;
         half_q = 1'b1;
      end
      depth_q = chain_input_n;
   end
   always @(negedge load_pulse_n)
   begin
      wok = clear_all_n && (cnt < WORDS);
      if (wok && cnt >= WORDS / 2)
         half_q = 1'b0;
   end
   always @(posedge load_pulse_n)
   begin
      if (wok)
      begin
         mem[wp] = dev_d;
         wp = (wp + 1) % WORDS;
         cnt++;
      end
      wok = 1'b0;
   end
   always @(negedge unload_pulse_n)
   begin
      rok = clear_all_n && (cnt > 0);
      if (rok)
         dev_q = mem[rp];
   end
   always @(posedge unload_pulse_n)
   begin
      if (rok)
      begin
         rp = (rp + 1) % WORDS;
         cnt--;
      end
      if (cnt <= WORDS / 2)
         half_q = 1'b1;
      rok = 1'b0;
      dev_q = ~dev_q;
   end
   always @(posedge lead_or_replay_n)
   begin
      if (clear_all_n && !depth_q)
      begin
         rp = 0;
         cnt = wp;
      end
   end
endmodule

/* File: dv/afc_host_tb_top.sv */
// bench for the fifo host controller
`timescale 1ns/10ps
module afc_host_tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic depth_mode = 1'b0;
   logic replay_req = 1'b0;
   logic wr_valid = 1'b0;
   logic [8:0] wr_data = 9'h000;
   logic [8:0] rd_data, dev_d, dev_q;
   logic wr_ready, rd_valid, clear_all_n, load_pulse_n, unload_pulse_n, lead_or_replay_n;
   logic full_n, empty_n, half_level_n, half_full, dev_full, dev_empty, busy;
   logic chain_output_n;
   logic saw_full = 1'b0;
   logic saw_half = 1'b0;
   logic saw_stall = 1'b0;
   logic [8:0] got_q[$];
   logic [8:0] exp_q[$];
   logic [8:0] hist[$];
   int error_cnt = 0;
   int comparisons = 0;
   int xo_cnt = 0;
   initial forever #5 sys_clk = ~sys_clk;
   afc_host #(.DATA_W(9), .DEVICES(1), .BUF_DEPTH(8)) i_afc_host (
      .sys_clk(sys_clk), .rst(rst), .depth_mode(depth_mode), .replay_req(replay_req),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .clear_all_n(clear_all_n), .load_pulse_n(load_pulse_n),
      .unload_pulse_n(unload_pulse_n), .lead_or_replay_n(lead_or_replay_n), .dev_d(dev_d),
      .dev_q(dev_q), .full_n(full_n), .empty_n(empty_n), .half_level_n(half_level_n),
      .half_full(half_full), .dev_full(dev_full), .dev_empty(dev_empty), .busy(busy));
   // chain input grounded in single mode, own chain output in depth
   afc_dev_model #(.WORDS(16)) i_afc_dev_model (
      .clear_all_n(clear_all_n), .load_pulse_n(load_pulse_n), .unload_pulse_n(unload_pulse_n),
      .lead_or_replay_n(lead_or_replay_n), .chain_input_n(depth_mode && chain_output_n), .dev_d(dev_d),
      .dev_q(dev_q), .full_n(full_n), .empty_n(empty_n), .half_level_n(half_level_n),
      .chain_output_n(chain_output_n));
   always @(negedge chain_output_n)
      xo_cnt++;
   always @(posedge sys_clk)
   begin
      if (rd_valid === 1'b1)
         got_q.push_back(rd_data);
      saw_full |= (dev_full === 1'b1);
      saw_half |= (half_full === 1'b1);
      saw_stall |= (wr_ready === 1'b0);
   end
   task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset(input logic dm);
      int n;
      depth_mode <= dm;
      rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      chk("clear", clear_all_n, 1'b0);
      chk("strobes", {load_pulse_n, unload_pulse_n}, 2'h3);
      rst <= 1'b0;
      n = 0;
      do
         @(negedge sys_clk);
      while ((clear_all_n !== 1'b1 || busy !== 1'b0) && n++ < 100);
      chk("clear end", clear_all_n, 1'b1);
      @(posedge sys_clk);
   endtask
   task automatic push(input logic [8:0] w);
      int n;
      wr_valid <= 1'b1;
      wr_data <= w;
      exp_q.push_back(w);
      n = 0;
      do
         @(negedge sys_clk);
      while (wr_ready !== 1'b1 && n++ < 3000);
      @(posedge sys_clk);
   endtask
   task automatic ex(input string s);
      int n;
      n = 0;
      while (got_q.size() < exp_q.size() && n++ < 4000)
         @(posedge sys_clk);
      repeat (80) @(posedge sys_clk);
      chk(s, 16'(got_q.size()), 16'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0)
         chk(s, got_q.pop_front(), exp_q.pop_front());
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic t_replay();
      for (int i = 0; i < 5; i++)
         push(9'h1A0 + 9'(i));
      wr_valid <= 1'b0;
      hist = exp_q;
      ex("stream");
      exp_q = hist;
      replay_req <= 1'b1;
      @(posedge sys_clk);
      replay_req <= 1'b0;
      ex("replay");
      $display("test replay done");
   endtask
   task automatic t_fill();
      saw_full = 1'b0;
      saw_half = 1'b0;
      saw_stall = 1'b0;
      xo_cnt = 0;
      for (int i = 0; i < 24; i++)
         push(9'h055 ^ 9'(i * 7));
      wr_valid <= 1'b0;
      ex("fill");
      chk("stall", saw_stall, 1'b1);
      chk("full", saw_full, 1'b1);
      chk("half", saw_half, 1'b1);
      chk("half end", half_full, 1'b0);
      chk("chain out", 16'(xo_cnt), 16'h0002);
      chk("empty end", dev_empty, 1'b1);
      $display("test fill done");
   endtask
   task automatic t_depth();
      do_reset(1'b1);
      for (int i = 0; i < 3; i++)
         push(9'h0C0 + 9'(i));
      wr_valid <= 1'b0;
      ex("depth");
      replay_req <= 1'b1;
      @(posedge sys_clk);
      replay_req <= 1'b0;
      repeat (300) @(posedge sys_clk);
      chk("depth replay", 16'(got_q.size()), 16'h0000);
      chk("lead", lead_or_replay_n, 1'b0);
      $display("test depth done");
   endtask
   initial
   begin
      do_reset(1'b0);
      t_replay();
      t_fill();
      t_depth();
      summarize();
   end
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
endmodule
